// [hw/dma_ctrl.sv]
`timescale 1ns/10ps
module dma_ctrl
	import dma_pkg::*;
(
	input  wire logic        CLOCK,
	input  wire logic        ARST_N,
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	input  wire logic [59:0] REQ_LINES,
	output logic      [31:0] MEM_ADDR,
	output logic      [1:0]  MEM_SIZE,
	output logic             MEM_RD,
	output logic             MEM_WR,
	output logic      [31:0] MEM_WDATA,
	input  wire logic [31:0] MEM_RDATA,
	input  wire logic        MEM_READY,
	input  wire logic        MEM_ERR,
	output logic      [3:0]  IRQ,
	output logic      [3:0]  CHAIN_REQ
);
	// ------------------------------------------------------------
	// per channel state
	// ------------------------------------------------------------
	logic [31:0] source_address_q [NCH];  // source cache
	logic [31:0] destination_address_q [NCH];  // destination cache
	logic [31:0] cnt_q  [NCH];  // count cache
	logic [31:0] cfg_q  [NCH];  // configuration
	logic [31:0] swork_q[NCH];  // working source
	logic [31:0] dwork_q[NCH];  // working destination
	logic [31:0] cwork_q[NCH];  // working counter
	logic [1:0]  smode_q[NCH];  // source step in force
	logic [1:0]  dmode_q[NCH];  // destination step in force
	logic [1:0]  wid_q  [NCH];  // width in force
	logic [NCH-1:0] tc_q, ht_q, te_q; // event flags
	logic [NCH-1:0] pend_q;     // request waiting for engine
	logic [NCH-1:0] swreq_q;    // software request
	logic [NCH-1:0] paused_q;   // working values kept for resume
	logic [NCH-1:0] chain_q;    // one cycle chain request

	// ------------------------------------------------------------
	// engine state
	// ------------------------------------------------------------
	eng_e        st_q;       // transfer phase
	logic [1:0]  act_q;      // channel being served
	logic [7:0]  bcnt_q;     // items left in this grant
	logic [31:0] data_q;     // item in flight
	logic [31:0] maddr_q;    // bus address
	logic [1:0]  msize_q;    // bus width
	logic [31:0] rdata_q;    // register read answer

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	wire [1:0] wch    = ADDR[7:6];
	wire [5:0] wsel   = ADDR[5:0];
	wire       wr_src = WR && (wsel == OFF_SRC);
	wire       wr_dst = WR && (wsel == OFF_DST);
	wire       wr_cfg = WR && (wsel == OFF_CFG);
	wire       wr_cnt = WR && (wsel == OFF_CNT);
	wire       wr_sts = WR && (wsel == OFF_STS);
	// a pause or reset write forces the enable off
	wire       on_new = WDATA[B_ON] && !WDATA[B_CLR] && !WDATA[B_PAUSE]; // RQ15

	logic [NCH-1:0] on, loop_en, bmode, chain_en;
	logic [NCH-1:0] hw_req, arb_req, any_flag;
	logic [2*NCH-1:0] prio_flat;
	logic [59+NCH:0]  req_all;
	logic        arb_valid;
	logic [1:0]  arb_grant;
	logic [31:0] cfg_new[NCH]; // config as this edge leaves it, so a mode sent with the enable lands

	// chain pulses sit at codes 60..63 above the peripheral lines
	assign req_all = {chain_q, REQ_LINES};

	// ------------------------------------------------------------
	// per channel decode
	// ------------------------------------------------------------
	for (genvar n = 0; n < NCH; n++) begin : g_dec
		wire [5:0] sel = cfg_q[n][B_SRCSEL +: 6];
		assign cfg_new[n]  = (wr_cfg && wch == n) ? WDATA : cfg_q[n];
		assign on[n]       = cfg_q[n][B_ON];
		assign loop_en[n]  = cfg_q[n][B_LOOP];
		assign bmode[n]    = cfg_q[n][B_TYPE];
		assign chain_en[n] = cfg_q[n][B_CHAIN];
		assign hw_req[n]   = src_valid(sel) && req_all[sel]; // RQ9
		assign arb_req[n]  = pend_q[n] && on[n];
		assign prio_flat[2*n +: 2] = cfg_q[n][B_PRIO +: 2];
		assign any_flag[n] = tc_q[n] || ht_q[n] || te_q[n];
		// gated by cpu enable, each event by its own enable
		assign IRQ[n] = cfg_q[n][B_CPUIE] && ((tc_q[n] && cfg_q[n][B_DONEIE]) ||
			(ht_q[n] && cfg_q[n][B_HALFIE]) ||
			(te_q[n] && cfg_q[n][B_ERRIE])); // RQ1 RQ2 RQ3 RQ23
	end

	dma_prio_arb #(.N(NCH), .IW(2)) u_arb (
		.req   (arb_req),
		.prio  (prio_flat),
		.valid (arb_valid),
		.grant (arb_grant)
	);

	// ------------------------------------------------------------
	// transfer events of the served channel
	// ------------------------------------------------------------
	wire        bus_end   = (st_q != ST_IDLE) && MEM_READY;
	wire        bus_err   = bus_end && MEM_ERR;
	wire        xfer_done = (st_q == ST_WR) && MEM_READY && !MEM_ERR;
	wire [31:0] cnt_nxt   = cwork_q[act_q] - 32'h1;
	wire        hit_zero  = xfer_done && (cnt_nxt == 32'h0);
	wire        hit_half  = xfer_done && (cnt_nxt == (cnt_q[act_q] >> 1));
	wire        reload    = hit_zero && loop_en[act_q];
	wire        eng_stop  = MEM_ERR || hit_zero || (bcnt_q == 8'h1) || !on[act_q];
	logic [31:0] s_next, d_next;

	dma_addr_step u_sstep (
		.addr  (swork_q[act_q]),
		.mode  (smode_q[act_q]),
		.width (wid_q[act_q]),
		.nxt   (s_next)
	);

	dma_addr_step u_dstep (
		.addr  (dwork_q[act_q]),
		.mode  (dmode_q[act_q]),
		.width (wid_q[act_q]),
		.nxt   (d_next)
	);

	// ------------------------------------------------------------
	// software registers and working values
	// ------------------------------------------------------------
	// caches take writes at any time; keeping to idle windows is up
	// to software, since a late write only lands at the next reload
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int n = 0; n < NCH; n++) begin
				source_address_q[n]  <= RST_WORD;
				destination_address_q[n]  <= RST_WORD;
				cnt_q[n]   <= RST_WORD;
				cfg_q[n]   <= RST_WORD;
				swork_q[n] <= RST_WORD;
				dwork_q[n] <= RST_WORD;
				cwork_q[n] <= RST_WORD;
				smode_q[n] <= MODE_FIX;
				dmode_q[n] <= MODE_FIX;
				wid_q[n]   <= WID_BYTE;
			end
		end else begin
			for (int n = 0; n < NCH; n++) begin
				if (wr_src && wch == n) source_address_q[n] <= WDATA; // RQ7
				if (wr_dst && wch == n) destination_address_q[n] <= WDATA;
				if (wr_cnt && wch == n) cnt_q[n]  <= WDATA;
				if (wr_cfg && wch == n) begin
					cfg_q[n]        <= WDATA & CFG_MASK;
					cfg_q[n][B_ON]  <= on_new; // RQ16 RQ17
					// a fresh start loads working copies; a resume keeps them
					if (on_new && !on[n] && !paused_q[n]) begin
						swork_q[n] <= source_address_q[n];
						dwork_q[n] <= destination_address_q[n];
						cwork_q[n] <= cnt_q[n];
					end
				end
				// step fields follow at once only while the channel is off
				if (!on[n] || (reload && act_q == n)) begin
					smode_q[n] <= cfg_new[n][B_SMODE +: 2]; // RQ14
					dmode_q[n] <= cfg_new[n][B_DMODE +: 2];
					wid_q[n]   <= cfg_new[n][B_WID +: 2];
				end
				if (xfer_done && act_q == n) begin
					swork_q[n] <= s_next; // RQ5
					dwork_q[n] <= d_next; // RQ8
					cwork_q[n] <= cnt_nxt; // RQ22
					if (reload) begin
						cwork_q[n] <= cnt_q[n]; // RQ22
						if (smode_q[n] == MODE_LOOP_MODE) swork_q[n] <= source_address_q[n]; // RQ6
						if (dmode_q[n] == MODE_LOOP_MODE) dwork_q[n] <= destination_address_q[n]; // RQ8
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// flags, requests, pause and chain
	// ------------------------------------------------------------
	// every hardware flag set is applied after the clears so that it wins
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			{tc_q, ht_q, te_q} <= '0;
			{pend_q, swreq_q, paused_q, chain_q} <= '0;
		end else begin
			chain_q <= '0;
			for (int n = 0; n < NCH; n++) begin
				if (wr_sts && wch == n) begin
					if (WDATA[1]) tc_q[n] <= 1'b0; // RQ19
					if (WDATA[2]) ht_q[n] <= 1'b0;
					if (WDATA[3]) te_q[n] <= 1'b0;
					if (WDATA[B_SWREQ]) swreq_q[n] <= 1'b1;
				end
				if (wr_cfg && wch == n) begin
					if (WDATA[B_CLR]) {tc_q[n], ht_q[n], te_q[n]} <= 3'h0; // RQ16
					if (WDATA[B_PAUSE] && on[n]) paused_q[n] <= 1'b1; // RQ17
					else if (on_new || WDATA[B_CLR]) paused_q[n] <= 1'b0; // RQ18
				end
				// a request needs an enabled channel with items left
				if (!on[n] && !paused_q[n]) pend_q[n] <= 1'b0;
				else if (on[n] && cwork_q[n] != 32'h0 && (hw_req[n] || swreq_q[n]))
					pend_q[n] <= 1'b1;
				// single mode consumes the request at grant
				if (st_q == ST_IDLE && arb_valid && arb_grant == n) begin
					swreq_q[n] <= 1'b0;
					if (!bmode[n]) pend_q[n] <= 1'b0; // RQ11
				end
				if (act_q == n) begin
					if (hit_zero || bus_err) pend_q[n] <= 1'b0; // RQ22
					if (hit_zero) tc_q[n] <= 1'b1; // RQ19
					if (hit_half) ht_q[n] <= 1'b1;
					if (bus_err) te_q[n] <= 1'b1;
					if (hit_zero && chain_en[n]) chain_q[n] <= 1'b1; // RQ10
				end
			end
		end
	end

	// ------------------------------------------------------------
	// transfer engine: read one item, then write it
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_q    <= ST_IDLE;
			act_q   <= 2'h0;
			bcnt_q  <= 8'h0;
			data_q  <= RST_WORD;
			maddr_q <= RST_WORD;
			msize_q <= WID_BYTE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (arb_valid) begin
						st_q    <= ST_RD;
						act_q   <= arb_grant;
						maddr_q <= swork_q[arb_grant];
						msize_q <= wid_q[arb_grant];
						bcnt_q  <= bmode[arb_grant] ?
							burst_len(cfg_q[arb_grant][B_BSZ +: 3]) : 8'h1; // RQ11 RQ12
					end
				end
				ST_RD: begin
					if (MEM_READY) begin
						st_q    <= MEM_ERR ? ST_IDLE : ST_WR;
						data_q  <= MEM_RDATA;
						maddr_q <= dwork_q[act_q];
					end
				end
				ST_WR: begin
					// a pause lets the running write finish first
					if (MEM_READY) begin
						st_q    <= eng_stop ? ST_IDLE : ST_RD; // RQ17
						bcnt_q  <= bcnt_q - 8'h1;
						maddr_q <= s_next;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// register read port: answer stands one cycle after the strobe
	// ------------------------------------------------------------
	wire [3:0] code_sel = (act_q == wch && st_q == ST_RD) ? CODE_RD :
		(act_q == wch && st_q == ST_WR) ? CODE_WR :
		arb_req[wch] ? CODE_PEND : CODE_IDLE;
	wire [31:0] sts_word = {23'h0, swreq_q[wch], code_sel,
		te_q[wch], ht_q[wch], tc_q[wch], any_flag[wch]};
	wire [31:0] rd_mux =
		(wsel == OFF_SRC) ? (on[wch] ? swork_q[wch] : source_address_q[wch]) : // RQ4
		(wsel == OFF_DST) ? (on[wch] ? dwork_q[wch] : destination_address_q[wch]) : // RQ8
		(wsel == OFF_CFG) ? cfg_q[wch] :
		(wsel == OFF_CNT) ? (on[wch] ? cwork_q[wch] : cnt_q[wch]) :
		(wsel == OFF_STS) ? sts_word : 32'h0;

	// unmapped offsets answer zero
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) rdata_q <= RST_WORD;
		else rdata_q <= RD ? rd_mux : 32'h0;
	end

	assign RDATA     = rdata_q;
	assign MEM_ADDR  = maddr_q;
	assign MEM_SIZE  = msize_q;
	assign MEM_WDATA = data_q;
	assign MEM_RD    = (st_q == ST_RD);
	assign MEM_WR    = (st_q == ST_WR);
	assign CHAIN_REQ = chain_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);

	sequence s_last_write;
		hit_zero && chain_en[act_q];
	endsequence
	sequence s_chain_pulse;
		(CHAIN_REQ != 4'h0) ##1 (CHAIN_REQ == 4'h0);
	endsequence

	irq_gate_a: assert property (!cfg_q[0][B_CPUIE] |-> !IRQ[0]) // RQ2
		else $error("interrupt passed with cpu enable low");
	irq_event_a: assert property (hit_zero && cfg_q[act_q][B_CPUIE] &&
		cfg_q[act_q][B_DONEIE] |=> IRQ[$past(act_q)]) // RQ23
		else $error("complete event did not raise interrupt");
	done_flag_a: assert property (hit_zero |=> tc_q[$past(act_q)]) // RQ19
		else $error("complete flag not set at zero");
	read_work_a: assert property (RD && wsel == OFF_SRC && on[wch]
		|=> RDATA == $past(swork_q[wch])) // RQ4
		else $error("source read did not return working address");
	step_src_a: assert property (xfer_done && !reload
		|=> swork_q[$past(act_q)] == $past(s_next)) // RQ5
		else $error("working source not stepped");
	chain_out_a: assert property (s_last_write |=> s_chain_pulse) // RQ10
		else $error("chain request not a single pulse");
	clear_off_a: assert property (wr_cfg && WDATA[B_CLR]
		|=> !on[$past(wch)] && !tc_q[$past(wch)]) // RQ16
		else $error("channel reset did not disable and clear");
	pause_stop_a: assert property (st_q == ST_WR && MEM_READY && !on[act_q]
		|=> st_q == ST_IDLE) // RQ17
		else $error("engine kept running after pause");
	burst_load_a: assert property (st_q == ST_IDLE && arb_valid && bmode[arb_grant]
		|=> bcnt_q == (BURST_MAX >> $past(cfg_q[arb_grant][B_BSZ +: 3]))) // RQ12
		else $error("burst length wrong");
	loop_back_a: assert property (reload
		|=> cwork_q[$past(act_q)] == $past(cnt_q[act_q])) // RQ22
		else $error("loop did not reload count");
endmodule

// [hw/dma_pkg.sv]
// What this block does
// RQ1 - four channels raise complete, half, error interrupts
// RQ2 - bit 16 gates channel interrupt to processor
// RQ3 - bits 19,18,17 enable error, half, complete
// RQ4 - source read: working when on, cache when off
// RQ5 - source working address steps by mode and width
// RQ6 - circular mode reloads cached address into working
// RQ7 - software writes caches only when off or idle; the caches here take writes at any time
// RQ8 - destination address behaves like the source one
// RQ9 - bits 29..24 select the hardware request source
// RQ10 - chain bit 23 issues request when transfer finishes
// RQ11 - bit 15 picks single or burst transfer type
// RQ12 - burst size code 000..111 gives 128 down to 1
// RQ13 - step codes: fixed, increment, decrement, circular
// RQ14 - step mode changes apply off or at reload
// RQ15 - bit 7 enables the channel
// RQ16 - writing bit 6 disables channel, clears flags
// RQ17 - pause bit 5 stops after current cycle, keeps state
// RQ18 - resume by writing enable one, pause zero
// RQ19 - flags set at zero, half, error; write-one clears
// RQ20 - width 00 byte, 01 half, 1x word
// RQ21 - priority arbitration, lower channel wins ties
// RQ22 - counter decrements; stops at zero or reloads in loop
// RQ23 - interrupt when cpu enable and enabled flag set
package dma_pkg;
	// ------------------------------------------------------------
	// register map: per channel window of 0x40 bytes
	// ------------------------------------------------------------
	localparam int         NCH     = 4;
	localparam logic [5:0] OFF_SRC = 6'h00; // source address cache
	localparam logic [5:0] OFF_DST = 6'h04; // destination address cache
	localparam logic [5:0] OFF_CFG = 6'h08; // channel configuration
	localparam logic [5:0] OFF_CNT = 6'h0c; // transfer count cache
	localparam logic [5:0] OFF_STS = 6'h10; // channel status
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [31:0] CFG_MASK = 32'h3f8f_ffbf; // reset bit never stored

	// ------------------------------------------------------------
	// configuration field positions
	// ------------------------------------------------------------
	localparam int B_SRCSEL = 24;
	localparam int B_CHAIN  = 23;
	localparam int B_ERRIE  = 19;
	localparam int B_HALFIE = 18;
	localparam int B_DONEIE = 17;
	localparam int B_CPUIE  = 16;
	localparam int B_TYPE   = 15;
	localparam int B_BSZ    = 12;
	localparam int B_SMODE  = 10;
	localparam int B_DMODE  = 8;
	localparam int B_ON     = 7;
	localparam int B_CLR    = 6;
	localparam int B_PAUSE  = 5;
	localparam int B_LOOP   = 4;
	localparam int B_WID    = 2;
	localparam int B_PRIO   = 0;
	localparam int B_SWREQ  = 8;  // status: software request

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_FIX  = 2'h0;
	localparam logic [1:0] MODE_INC  = 2'h1;
	localparam logic [1:0] MODE_DEC  = 2'h2;
	localparam logic [1:0] MODE_LOOP_MODE = 2'h3;
	localparam logic [1:0] WID_BYTE  = 2'h0;
	localparam logic [1:0] WID_HALF  = 2'h1;
	localparam logic [3:0] CODE_IDLE = 4'h0;
	localparam logic [3:0] CODE_RD   = 4'h1;
	localparam logic [3:0] CODE_WR   = 4'h2;
	localparam logic [3:0] CODE_PEND = 4'h5;
	localparam logic [7:0] BURST_MAX = 8'h80;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RD   = 3'b010,
		ST_WR   = 3'b100
	} eng_e;

	// burst length: 000 gives 128, each step halves
	function automatic logic [7:0] burst_len(input logic [2:0] code);
		return BURST_MAX >> code;
	endfunction

	// listed request source codes; all others mean no request
	function automatic logic src_valid(input logic [5:0] sel);
		return sel inside {[6'd2:6'd5], [6'd12:6'd15], [6'd20:6'd21],
			[6'd33:6'd38], [6'd48:6'd50], [6'd59:6'd63]};
	endfunction
endpackage

// [hw/dma_addr_step.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// address stepper: next working address from mode and width
// ----------------------------------------------------------------
module dma_addr_step
	import dma_pkg::*;
(
	input  wire logic [31:0] addr,
	input  wire logic [1:0]  mode,
	input  wire logic [1:0]  width,
	output logic      [31:0] nxt
);
	logic [31:0] step; // byte distance of one item

	// 1x widths are both word sized
	assign step = (width == WID_BYTE) ? 32'h1 :
		(width == WID_HALF) ? 32'h2 : 32'h4; // RQ20

	// circular steps upward like increment; wrap is the reload
	assign nxt = (mode == MODE_FIX) ? addr :
		(mode == MODE_DEC) ? addr - step : addr + step; // RQ13
endmodule

// [hw/dma_prio_arb.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// priority arbiter: highest level wins, ties to lowest index
// ----------------------------------------------------------------
module dma_prio_arb #(
	parameter int N  = 4,
	parameter int IW = 2
) (
	input  wire logic [N-1:0]   req,
	input  wire logic [2*N-1:0] prio,
	output logic                valid,
	output logic [IW-1:0]       grant
);
	logic [1:0] best; // level of current winner

	// scan downward so an equal level at a lower index overrides
	always_comb begin
		valid = 1'b0;
		grant = '0;
		best  = 2'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i] && (!valid || prio[2*i +: 2] >= best)) begin
				valid = 1'b1;
				best  = prio[2*i +: 2];
				grant = IW'(i); // RQ21
			end
		end
	end
endmodule

// [tb/dma_mem_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// system bus memory: answers each phase, promptly or slowly
// ----------------------------------------------------------------
module dma_mem_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [31:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic        slow,      // adds three wait cycles per phase
	output logic             mem_ready,
	output logic             mem_err,
	output logic      [31:0] mem_rdata
);
	logic [1:0] wait_q; // cycles waited in the current phase

	// one ready pulse per phase; the guard on ready stops a double answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q    <= 2'h0;
			mem_ready <= 1'b0;
			mem_err   <= 1'b0;
			mem_rdata <= 32'h0;
		end else begin
			mem_ready <= 1'b0;
			mem_err   <= 1'b0;
			// outside a valid answer the data keep moving, never a stale word
			mem_rdata <= ~mem_rdata;
			if ((mem_rd || mem_wr) && !mem_ready) begin
				if (wait_q == (slow ? 2'h3 : 2'h0)) begin
					mem_ready <= 1'b1;
					// top nibble f is the undefined region of this memory
					mem_err   <= (mem_addr[31:28] == 4'hf);
					mem_rdata <= mem_addr ^ 32'h5a5a_0000;
					wait_q    <= 2'h0;
				end else begin
					wait_q <= wait_q + 2'h1;
				end
			end
		end
	end
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
	$display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module tb;
	import dma_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        CLOCK, ARST_N, WR, RD, slow, mem_rd, mem_wr, mem_ready, mem_err;
	logic [7:0]  ADDR;
	logic [31:0] WDATA, RDATA, mem_addr, mem_wdata, mem_rdata, rdat, src, dst, cfg, v;
	logic [59:0] REQ_LINES;
	logic [1:0]  mem_size, cur_w;  // cur_w: width expected on the bus
	logic [3:0]  IRQ, CHAIN_REQ;
	logic [31:0] ra_q[$], wa_q[$]; // read and write addresses seen
	int          failures, checked, chain_n, n;
	byte         codes[] = '{2, 3, 4, 5, 12, 13, 14, 15, 20, 21, 33, 34, 35, 36, 37, 38,
		48, 49, 50, 59};

	dma_ctrl u_dut (.CLOCK(CLOCK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .REQ_LINES(REQ_LINES), .MEM_ADDR(mem_addr),
		.MEM_SIZE(mem_size), .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata),
		.MEM_RDATA(mem_rdata), .MEM_READY(mem_ready), .MEM_ERR(mem_err), .IRQ(IRQ),
		.CHAIN_REQ(CHAIN_REQ));
	dma_mem_model u_mem (.clk(CLOCK), .rst_n(ARST_N), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .slow(slow), .mem_ready(mem_ready), .mem_err(mem_err),
		.mem_rdata(mem_rdata));

	always #10 CLOCK = ~CLOCK;

	// bus monitor: records finished phases, checks width on reads and written data at word width
	always @(posedge CLOCK) begin
		if (CHAIN_REQ[0]) chain_n++;
		if (mem_ready && mem_rd) begin
			ra_q.push_back(mem_addr);
			rdat = mem_rdata;
			`CHK("size", cur_w, mem_size)
		end
		if (mem_ready && mem_wr) begin
			wa_q.push_back(mem_addr);
			if (cur_w[1]) `CHK("wdata", rdat, mem_wdata)
		end
	end

	// ------------------------------------------------------------
	// bus tasks and expectations
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		ADDR  <= a;
		WDATA <= d;
		WR    <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge CLOCK);
		ADDR <= a;
		RD   <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1;
		v = RDATA;
		if (nm != "") `CHK(nm, e, v)
	endtask

	// bounded poll of one status bit
	task automatic wait_flag(input logic [1:0] ch, input int b);
		for (int k = 0; k < 300; k++) begin
			chk_rd("", {ch, OFF_STS}, 0);
			if (v[b] === 1'b1) return;
		end
		`CHK("flag wait", 1'b1, 1'b0)
	endtask

	task automatic setup(input logic [1:0] ch, input logic [31:0] s, d, c, f);
		wr({ch, OFF_SRC}, s);
		wr({ch, OFF_DST}, d);
		wr({ch, OFF_CNT}, c);
		wr({ch, OFF_CFG}, f);
	endtask

	function automatic logic [31:0] step(input logic [31:0] a, input int m, w);
		int b = (w == 0) ? 1 : (w == 1) ? 2 : 4;
		return (m == 0) ? a : (m == 2) ? a - b : a + b;
	endfunction

	task automatic print_verdict;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge CLOCK);
		failures++;
		print_verdict();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{CLOCK, ARST_N, WR, RD, slow, ADDR, WDATA, REQ_LINES, cur_w} = '0;
		void'($urandom(32'h2079));
		repeat (6) @(posedge CLOCK);
		ARST_N <= 1'b1;
		// reset values, unmapped place
		for (int c = 0; c < 4; c++)
			for (int o = 0; o < 6'h14; o += 4) chk_rd("reset", {c[1:0], o[5:0]}, 0);
		wr(8'h14, $urandom);
		chk_rd("unmapped", 8'h14, 0);
		`CHK("irq reset", 4'h0, IRQ)
		// random configuration words, channel kept off
		for (int i = 0; i < 8; i++) begin
			cfg = $urandom & 32'hffff_ff1f;
			wr({i[1:0], OFF_CFG}, cfg);
			chk_rd("cfg", {i[1:0], OFF_CFG}, cfg & CFG_MASK);
			wr({i[1:0], OFF_CFG}, 0);
		end
		// fixed, increment and decrement step modes against every width, two items
		for (int m = 0; m < 3; m++) for (int w = 0; w < 3; w++) begin
			src = $urandom & 32'h0fff_fffc;
			dst = src ^ 32'h0100_0000;
			cur_w = w[1:0];
			ra_q.delete();
			wa_q.delete();
			cfg = 32'h0003_f080 | (m << 10) | ((2 - m) << 8) | (w << 2);
			setup(0, src, dst, 2, cfg);
			wr({2'h0, OFF_STS}, 32'h100);
			wait_flag(0, 1);
			chk_rd("src work", {2'h0, OFF_SRC}, step(step(src, m, w), m, w));
			chk_rd("dst work", {2'h0, OFF_DST}, step(step(dst, 2 - m, w), 2 - m, w));
			`CHK("rd addr", step(src, m, w), ra_q[1])
			`CHK("wr addr", step(dst, 2 - m, w), wa_q[1])
			chk_rd("flags", {2'h0, OFF_STS}, 32'h7);
			`CHK("irq on", 1'b1, IRQ[0])
			wr({2'h0, OFF_CFG}, cfg & ~32'h1_0000);
			#1 `CHK("irq gated", 1'b0, IRQ[0])
			wr({2'h0, OFF_STS}, 32'he);
			chk_rd("cleared", {2'h0, OFF_STS}, 0);
			wr({2'h0, OFF_CFG}, 0);
			chk_rd("src cache", {2'h0, OFF_SRC}, src);
		end
		// circular source in loop mode reloads at zero
		setup(0, 32'h500, 32'h600, 2, 32'h0000_fd98);
		wr({2'h0, OFF_STS}, 32'h100);
		wait_flag(0, 1);
		chk_rd("loop_mode src", {2'h0, OFF_SRC}, 32'h500);
		chk_rd("loop cnt", {2'h0, OFF_CNT}, 2);
		setup(0, 0, 0, 0, 0);
		cur_w = 2'h0;
		// listed peripheral request codes
		foreach (codes[i]) begin
			setup(2, 32'h100, 32'h200, 1, 32'h80 | (codes[i] << 24));
			REQ_LINES <= 60'h1 << codes[i];
			wait_flag(2, 1);
			REQ_LINES <= '0;
			wr({2'h2, OFF_STS}, 32'he);
			wr({2'h2, OFF_CFG}, 0);
		end
		// code 0 and unlisted codes ignore every line
		REQ_LINES <= '1;
		foreach (codes[i]) if (i < 3) begin
			n = wa_q.size();
			setup(2, 32'h100, 32'h200, 1, 32'h80 | ((i * 9 % 27) << 24));
			repeat (30) @(posedge CLOCK);
			`CHK("no request", n, wa_q.size())
			wr({2'h2, OFF_CFG}, 0);
		end
		REQ_LINES <= '0;
		// chaining: channel 1 served by channel 0 finishing
		chain_n = 0;
		setup(1, 32'h300, 32'h400, 1, 32'h3c00_0080);
		setup(0, 32'h100, 32'h200, 1, 32'h0080_0080);
		wr({2'h0, OFF_STS}, 32'h100);
		wait_flag(1, 1);
		`CHK("chain pulses", 1, chain_n)
		// channel reset drops both channels and their stale flags
		wr({2'h0, OFF_CFG}, 32'h40);
		wr({2'h1, OFF_CFG}, 32'h40);
		// one request line for two channels: level first, then the index
		for (int p = 0; p < 2; p++) begin
			ra_q.delete();
			setup(0, 32'h100, 32'h200, 1, 32'h0200_0080);
			setup(1, 32'h700, 32'h800, 1, 32'h0200_0080 | (p ? 0 : 3));
			REQ_LINES <= 60'h4;
			wait_flag(0, 1);
			wait_flag(1, 1);
			REQ_LINES <= '0;
			`CHK("prio", p ? 32'h100 : 32'h700, ra_q[0])
			wr({2'h0, OFF_CFG}, 32'h40);
			wr({2'h1, OFF_CFG}, 32'h40);
		end
		// error on undefined address, enables, channel clear
		setup(3, 32'hf000_0000, 32'h200, 2, 32'h0009_0080);
		wr({2'h3, OFF_STS}, 32'h100);
		wait_flag(3, 3);
		#1 `CHK("irq err", 1'b1, IRQ[3])
		wr({2'h3, OFF_CFG}, 32'h0003_0080);
		#1 `CHK("irq err off", 1'b0, IRQ[3])
		wr({2'h3, OFF_CFG}, 32'h0003_00c0);
		chk_rd("clr cfg", {2'h3, OFF_CFG}, 32'h0003_0000);
		chk_rd("clr flags", {2'h3, OFF_STS}, 0);
		chk_rd("clr src", {2'h3, OFF_SRC}, 32'hf000_0000);
		// pause in mid burst under a slow memory, then resume
		slow <= 1'b1;
		cur_w = 2'h2;
		wa_q.delete();
		cfg = 32'h0000_d588;
		setup(0, 32'h1000, 32'h2000, 4, cfg);
		wr({2'h0, OFF_STS}, 32'h100);
		for (int k = 0; k < 200 && wa_q.size() == 0; k++) @(posedge CLOCK);
		wr({2'h0, OFF_CFG}, cfg | 32'h20);
		repeat (30) @(posedge CLOCK);
		n = wa_q.size();
		`CHK("paused", 1'b1, n < 4)
		repeat (20) @(posedge CLOCK);
		`CHK("held", n, wa_q.size())
		wr({2'h0, OFF_CFG}, cfg);
		wr({2'h0, OFF_STS}, 32'h100);
		wait_flag(0, 1);
		`CHK("items", 4, wa_q.size())
		`CHK("last dst", 32'h200c, wa_q[3])
		print_verdict();
	end
endmodule
